// >>> shared/vme_bridge_pkg.sv
package vme_bridge_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock bounds for the strobe sampler
   localparam int CLK_PERIOD_NS    = 20;
   localparam int CLK_MIN_KHZ      = 33333;
   localparam int CLK_MAX_KHZ      = 50000;
   localparam int CLK_RATE_KHZ     = 1000000 / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Accepted address modifier codes
   localparam logic [5:0] AM_CODE_0 = 6'h3E;
   localparam logic [5:0] AM_CODE_1 = 6'h3D;
   localparam logic [5:0] AM_CODE_2 = 6'h3A;
   localparam logic [5:0] AM_CODE_3 = 6'h39;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and widths
   localparam int BASE_HI     = 23;
   localparam int BASE_LO     = 19;
   localparam int BASE_W      = BASE_HI - BASE_LO + 1;
   localparam int ADR_HI      = 18;
   localparam int ADR_LO      = 2;
   localparam int ADR_W       = ADR_HI - ADR_LO + 1;
   localparam int SEL_W       = 4;
   localparam int DAT_W       = 32;

   // Tags: address tag bit 0 = A24 space; cycle tag 0 = single data cycle
   localparam int TGA_W       = 1;
   localparam int TGC_W       = 2;
   localparam logic [TGA_W-1:0] TGA_A24    = 1'h1;
   localparam logic [TGC_W-1:0] TGC_SINGLE = 2'h0;

   // Extra settle cycles before the read acknowledge
   localparam logic [1:0] READ_SETTLE = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_STROBE = 3'b001,
      ST_SETTLE = 3'b010,
      ST_TERM   = 3'b011,
      ST_WAIT   = 3'b100
   } seq_state_t;

   typedef struct packed
   {
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
      logic [TGA_W-1:0] tga;
      logic [TGC_W-1:0] tgc;
      logic             we;
   } wb_req_t;

endpackage

// >>> rtl/vme_a24_slave_to_wishbone_master.sv
// Notes on behaviour
// - On retry, release and repeat the cycle.
// - Drive one select per byte lane.
// - Strobe marks the valid transfer phase.
// - Address tag travels with the address.
// - Cycle tag qualified by cycle output.
// - Write enable low reads, high writes.
// - DTACK one edge after ack; reads one more.
// - Error termination drives bus error instead.
// - Select on AM code, base match, enable.
// - Selects held until termination or strobe abort.
`timescale 1ns/1ns
module vme_a24_slave_to_wishbone_master
(
   // Clock, reset, enable
   input  wire logic                               clk_in,
   input  wire logic                               rst_b_in,
   input  wire logic                               clk_en_in,
   // VMEbus side (active-low strobes)
   input  wire logic [23:1]                        vme_addr_in,
   input  wire logic [5:0]                         vme_am_in,
   input  wire logic [31:0]                        vme_data_in,
   input  wire logic                               vme_as_b_in,
   input  wire logic                               vme_ds0_b_in,
   input  wire logic                               vme_ds1_b_in,
   input  wire logic                               vme_lword_b_in,
   input  wire logic                               vme_iack_b_in,
   input  wire logic                               vme_write_b_in,
   output logic [31:0]                             vme_data_out,
   output logic                                    vme_data_oe_b_out,
   output logic                                    vme_transfer_ack_out,
   output logic                                    vme_bus_error_out,
   // Base address and enable
   input  wire logic [vme_bridge_pkg::BASE_W-1:0]  slave_base_compare_in,
   input  wire logic                               slave_enable_in,
   // WISHBONE master
   output logic                                    cyc_out,
   output logic                                    stb_out,
   output logic                                    we_out,
   output logic [vme_bridge_pkg::ADR_W-1:0]        adr_out,
   output logic [vme_bridge_pkg::SEL_W-1:0]        sel_out,
   output logic [vme_bridge_pkg::DAT_W-1:0]        dat_out,
   output logic [vme_bridge_pkg::TGA_W-1:0]        tga_out,
   output logic [vme_bridge_pkg::TGC_W-1:0]        tgc_out,
   output logic                                    a24_active_out,
   input  wire logic [vme_bridge_pkg::DAT_W-1:0]   dat_in,
   input  wire logic                               ack_in,
   input  wire logic                               err_in,
   input  wire logic                               rty_in
);
   import vme_bridge_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for all backplane inputs
   localparam int SYNC_W = 23 + 6 + 32 + 6 + BASE_W + 1;
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [SYNC_W-1:0] sync_next;

   always_comb
   begin
      sync_next = {vme_addr_in, vme_am_in, vme_data_in, vme_as_b_in,
                   vme_ds0_b_in, vme_ds1_b_in, vme_lword_b_in,
                   vme_iack_b_in, vme_write_b_in, slave_base_compare_in,
                   slave_enable_in};
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end
      else if (clk_en_in)
      begin
         sync1_reg <= sync_next;
         sync2_reg <= sync1_reg;
      end
   end

   logic [23:1] s_addr;
   logic [5:0]  s_am;
   logic [31:0] s_data;
   logic        s_as_b;
   logic        s_ds0_b;
   logic        s_ds1_b;
   logic        s_lword_b;
   logic        s_iack_b;
   logic        s_write_b;
   logic [4:0]  s_base;
   logic        s_en;

   assign {s_addr, s_am, s_data, s_as_b, s_ds0_b, s_ds1_b, s_lword_b,
           s_iack_b, s_write_b, s_base, s_en} = sync2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode and lane selection
   logic       am_ok;
   logic       selected;
   logic       ds_any;
   logic       ds_both;
   logic [3:0] lanes;

   always_comb
   begin
      am_ok = (s_am == AM_CODE_0) || (s_am == AM_CODE_1) ||
              (s_am == AM_CODE_2) || (s_am == AM_CODE_3);
      selected = am_ok && s_en && !s_as_b && s_iack_b &&
                 (s_addr[BASE_HI:BASE_LO] == s_base);
      ds_any  = !s_ds0_b || !s_ds1_b;
      ds_both = !s_ds0_b && !s_ds1_b;
      lanes   = 4'h0;
      if (!s_lword_b)
      begin
         lanes = 4'hF;
      end
      else if (s_addr[1])
      begin
         lanes = {2'h0, !s_ds1_b, !s_ds0_b};
      end
      else
      begin
         lanes = {!s_ds1_b, !s_ds0_b, 2'h0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   seq_state_t  state_reg;
   seq_state_t  state_next;
   wb_req_t     req_reg;
   wb_req_t     req_next;
   logic        cyc_reg;
   logic        cyc_next;
   logic        dtack_reg;
   logic        dtack_next;
   logic        berr_reg;
   logic        berr_next;
   logic        drive_reg;
   logic        drive_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0]  settle_reg;
   logic [1:0]  settle_next;
   logic        abort;
   logic        go;

   always_comb
   begin
      state_next  = state_reg;
      req_next    = req_reg;
      cyc_next    = cyc_reg;
      dtack_next  = dtack_reg;
      berr_next   = berr_reg;
      drive_next  = drive_reg;
      rdata_next  = rdata_reg;
      settle_next = settle_reg;
      abort       = !ds_both && !(s_lword_b && ds_any);
      go          = selected && ds_any &&
                    (ds_both || (s_lword_b && ds_any));
      case (state_reg)
         ST_IDLE:
         begin
            if (go)
            begin
               req_next.adr = s_addr[ADR_HI:ADR_LO];
               req_next.sel = lanes;
               req_next.we  = !s_write_b;
               req_next.dat = s_data;
               req_next.tga = TGA_A24;
               req_next.tgc = TGC_SINGLE;
               cyc_next     = 1'b1;
               state_next   = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            if (abort)
            begin
               cyc_next     = 1'b0;
               req_next.sel = 4'h0;
               state_next   = ST_IDLE;
            end
            else if (ack_in || err_in)
            begin
               cyc_next     = 1'b0;
               req_next.sel = 4'h0;
               rdata_next   = dat_in;
               if (err_in)
               begin
                  berr_next  = 1'b1;
                  state_next = ST_TERM;
               end
               else if (req_reg.we)
               begin
                  dtack_next = 1'b1;
                  state_next = ST_TERM;
               end
               else
               begin
                  drive_next  = 1'b1;
                  settle_next = READ_SETTLE;
                  state_next  = ST_SETTLE;
               end
            end
            else if (rty_in)
            begin
               cyc_next   = 1'b0;
               state_next = ST_WAIT;
            end
         end
         ST_SETTLE:
         begin
            settle_next = settle_reg - 2'h1;
            if (settle_reg == 2'h1)
            begin
               dtack_next = 1'b1;
               state_next = ST_TERM;
            end
         end
         ST_TERM:
         begin
            if (!ds_any)
            begin
               dtack_next = 1'b0;
               berr_next  = 1'b0;
               drive_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         ST_WAIT:
         begin
            if (abort)
            begin
               req_next.sel = 4'h0;
               state_next   = ST_IDLE;
            end
            else
            begin
               cyc_next   = 1'b1;
               state_next = ST_STROBE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_reg  <= ST_IDLE;
         req_reg    <= '0;
         cyc_reg    <= 1'b0;
         dtack_reg  <= 1'b0;
         berr_reg   <= 1'b0;
         drive_reg  <= 1'b0;
         rdata_reg  <= '0;
         settle_reg <= 2'h0;
      end
      else if (clk_en_in)
      begin
         state_reg  <= state_next;
         req_reg    <= req_next;
         cyc_reg    <= cyc_next;
         dtack_reg  <= dtack_next;
         berr_reg   <= berr_next;
         drive_reg  <= drive_next;
         rdata_reg  <= rdata_next;
         settle_reg <= settle_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; backplane acknowledges are active low
   assign cyc_out              = cyc_reg;
   assign stb_out              = cyc_reg;
   assign we_out               = req_reg.we;
   assign adr_out              = req_reg.adr;
   assign sel_out              = req_reg.sel;
   assign dat_out              = req_reg.dat;
   assign tga_out              = req_reg.tga;
   assign tgc_out              = req_reg.tgc;
   assign a24_active_out       = cyc_reg;
   assign vme_data_out         = rdata_reg;
   assign vme_data_oe_b_out    = !drive_reg;
   assign vme_transfer_ack_out = !dtack_reg;
   assign vme_bus_error_out    = !berr_reg;
endmodule

// >>> tb/wb_slave_model.sv
`timescale 1ns/1ns
module wb_slave_model
(
   // Bus side
   input  wire logic        clk_in,
   input  wire logic        stb_in,
   input  wire logic        we_in,
   input  wire logic [31:0] dat_in,
   // Answer: 0 ack, 1 error, 2 one retry then ack
   input  wire logic [1:0]  mode_in,
   input  wire logic [2:0]  wait_in,
   output logic      [31:0] dat_out,
   output logic             ack_out,
   output logic             err_out,
   output logic             rty_out
);
   logic [2:0]  cnt = '0;
   logic [31:0] mem = '0;
   logic        tried = '0;
   initial {dat_out, ack_out, err_out, rty_out} = '0;
   always @(posedge clk_in)
   begin
      {ack_out, err_out, rty_out} <= 3'h0;
      dat_out <= ~dat_out;   // Data is not held between answers
      if (!stb_in || ack_out || err_out || rty_out)
         cnt <= 3'h0;
      else if (cnt < wait_in)
         cnt <= cnt + 3'h1;
      else if (mode_in == 2'h1)
         err_out <= 1'h1;
      else if (mode_in == 2'h2 && !tried)
      begin
         rty_out <= 1'h1;
         tried   <= 1'h1;
      end
      else
      begin
         ack_out <= 1'h1;
         tried   <= 1'h0;
         dat_out <= mem;
         if (we_in)
            mem <= dat_in;
      end
   end
endmodule

// >>> tb/vme_bridge_props.sv
`timescale 1ns/1ns
module vme_bridge_props
   import vme_bridge_pkg::*;
(
   input wire logic             clk_in,
   input wire logic             rst_b_in,
   input wire logic             cyc_out,
   input wire logic             stb_out,
   input wire logic             we_out,
   input wire logic [SEL_W-1:0] sel_out,
   input wire logic [TGA_W-1:0] tga_out,
   input wire logic [TGC_W-1:0] tgc_out,
   input wire logic             ack_in,
   input wire logic             err_in,
   input wire logic             rty_in,
   input wire logic             vme_transfer_ack_out,
   input wire logic             vme_bus_error_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_gap;
      !cyc_out ##1 cyc_out;
   endsequence
   sequence s_rd_ack;
      vme_transfer_ack_out ##1 !vme_transfer_ack_out;
   endsequence
   a_stb_cyc_same: assert property (stb_out == cyc_out)
      else $error("strobe and cycle differ");
   a_stb_term_drop: assert property (stb_out && (ack_in || err_in ||
      rty_in) |=> !stb_out) else $error("strobe held after termination");
   a_sel_lanes: assert property (cyc_out |-> sel_out != 4'h0)
      else $error("no byte lane selected");
   a_tags_set: assert property (cyc_out |-> tga_out == TGA_A24
      && tgc_out == TGC_SINGLE) else $error("tag value wrong");
   a_we_steady: assert property (cyc_out && $past(cyc_out)
      |-> $stable(we_out)) else $error("write enable moved");
   a_sel_held: assert property (cyc_out && $past(cyc_out)
      |-> $stable(sel_out)) else $error("select moved in cycle");
   a_wr_dtack: assert property (cyc_out && we_out && ack_in &&
      !err_in |=> !vme_transfer_ack_out) else $error("write ack late");
   a_rd_dtack: assert property (cyc_out && !we_out && ack_in &&
      !err_in |=> s_rd_ack) else $error("read ack timing wrong");
   a_err_berr: assert property (cyc_out && err_in |=>
      !vme_bus_error_out && vme_transfer_ack_out)
      else $error("bus error not given");
   a_retry_gap: assert property (cyc_out && rty_in && !ack_in
      && !err_in |=> s_gap) else $error("retry not repeated");
endmodule
bind vme_a24_slave_to_wishbone_master vme_bridge_props i_props (.*);

// >>> tb/vme_a24_slave_to_wishbone_master_tb.sv
`timescale 1ns/1ns
module vme_a24_slave_to_wishbone_master_tb;
   import vme_bridge_pkg::*;
   localparam logic [23:0] adr_a = 24'h50_1234;
   logic clk_in = '0, rst_b_in = '0, clk_en_in = '1;
   logic [23:1] vme_addr_in = '0;
   logic [5:0] vme_am_in = '0;
   logic [31:0] vme_data_in = '0, vme_data_out, dat_out, dat_in, s_dat;
   logic vme_as_b_in = '1, vme_ds0_b_in = '1, vme_ds1_b_in = '1;
   logic vme_lword_b_in = '1, vme_iack_b_in = '1, vme_write_b_in = '1;
   logic vme_data_oe_b_out, vme_transfer_ack_out, vme_bus_error_out;
   logic [BASE_W-1:0] slave_base_compare_in = 5'h0A;
   logic slave_enable_in = '1, cyc_out, stb_out, we_out, a24_active_out;
   logic [ADR_W-1:0] adr_out, s_adr;
   logic [SEL_W-1:0] sel_out, s_sel;
   logic [TGA_W-1:0] tga_out;
   logic [TGC_W-1:0] tgc_out;
   logic ack_in, err_in, rty_in, s_we, stb_d = '0;
   logic [1:0] mode = '0, res;
   logic [2:0] dly = '0;
   int mismatches = 0, n_checks = 0, n_stb = 0;
   always #10 clk_in = ~clk_in;   // 50 MHz sampling clock
   always @(posedge clk_in)
   begin
      stb_d <= stb_out;
      if (stb_out && !stb_d)
         n_stb <= n_stb + 1;
   end
   vme_a24_slave_to_wishbone_master i_vme_a24_slave_to_wishbone_master (.*);
   wb_slave_model i_wb_slave_model (.clk_in, .stb_in(stb_out),
      .we_in(we_out), .dat_in(dat_out), .mode_in(mode), .wait_in(dly),
      .dat_out(dat_in), .ack_out(ack_in), .err_out(err_in),
      .rty_out(rty_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One backplane cycle; res = {dtack seen, bus error seen}
   task automatic vme(input logic [23:0] a, input logic [5:0] am,
      input logic wr, lw, input logic [1:0] ds, input logic [31:0] d,
      input logic ab);
      res = '0;
      n_stb = 0;
      @(posedge clk_in);
      vme_addr_in <= a[23:1];
      vme_am_in <= am;
      vme_write_b_in <= !wr;
      vme_lword_b_in <= lw;
      vme_data_in <= d;
      vme_as_b_in <= 1'h0;
      @(posedge clk_in);
      {vme_ds1_b_in, vme_ds0_b_in} <= ds;
      for (int i = 0; i < 40 && res === 2'h0; i++)
      begin
         @(posedge clk_in);
         if (ab && n_stb > 0)
            {vme_ds1_b_in, vme_ds0_b_in} <= 2'h3;
         #1;
         if (stb_out)
            {s_sel, s_adr, s_we, s_dat} = {sel_out, adr_out, we_out, dat_out};
         if (stb_out)
            chk(a24_active_out, 1'h1);
         res = {!vme_transfer_ack_out, !vme_bus_error_out};
      end
      if (!wr && res === 2'h2)
      begin
         chk(vme_data_out, d);
         chk(vme_data_oe_b_out, 1'h0);
      end
      @(posedge clk_in);
      {vme_ds1_b_in, vme_ds0_b_in, vme_as_b_in} <= 3'h7;
      repeat (6) @(posedge clk_in);
      chk(vme_transfer_ack_out & vme_bus_error_out, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_rw;
      vme(adr_a, AM_CODE_0, 1'h1, 1'h0, 2'h0, 32'hCAFE_F00D, 1'h0);
      chk(res, 2'h2);
      chk(s_sel, 4'hF);
      chk(s_we, 1'h1);
      chk(s_adr, adr_a[18:2]);
      chk(s_dat, 32'hCAFE_F00D);
      chk(n_stb, 1);
      vme(adr_a, AM_CODE_1, 1'h0, 1'h0, 2'h0, 32'hCAFE_F00D, 1'h0);
      chk(res, 2'h2);
      chk(s_we, 1'h0);
      chk(vme_data_oe_b_out, 1'h1);
   endtask
   task automatic t_d16;
      vme(adr_a | 24'h2, AM_CODE_2, 1'h0, 1'h1, 2'h2, 32'hCAFE_F00D, 1'h0);
      chk(res, 2'h2);
      chk(s_sel, 4'h1);
      vme(adr_a, AM_CODE_3, 1'h1, 1'h1, 2'h1, 32'h0, 1'h0);
      chk(res, 2'h2);
      chk(s_sel, 4'h8);
      vme(adr_a, AM_CODE_3, 1'h0, 1'h1, 2'h0, 32'h0, 1'h0);
      chk(res, 2'h2);
      chk(s_sel, 4'hC);
   endtask
   task automatic t_err_retry;
      mode = 2'h1;
      vme(adr_a, AM_CODE_0, 1'h1, 1'h0, 2'h0, 32'h5, 1'h0);
      chk(res, 2'h1);
      mode = 2'h2;
      dly = 3'h3;
      vme(adr_a, AM_CODE_0, 1'h1, 1'h0, 2'h0, 32'h6, 1'h0);
      chk(res, 2'h2);
      chk(n_stb, 2);
      mode = 2'h0;
      dly = 3'h7;
      vme(adr_a, AM_CODE_0, 1'h1, 1'h0, 2'h0, 32'h7, 1'h1);
      chk(res, 2'h0);
      chk(cyc_out, 1'h0);
      dly = 3'h0;
   endtask
   task automatic t_decode;
      logic [5:0] am_ok [4] = '{AM_CODE_0, AM_CODE_1, AM_CODE_2, AM_CODE_3};
      foreach (am_ok[k])
      begin
         vme(adr_a, am_ok[k], 1'h1, 1'h0, 2'h0, 32'h1, 1'h0);
         chk(res, 2'h2);
      end
      for (int k = 0; k < 4; k++)
      begin
         slave_enable_in <= (k != 2);
         vme_iack_b_in <= (k != 3);
         vme(k == 1 ? 24'h70_0000 : adr_a, k == 0 ? 6'h09 : AM_CODE_0,
            1'h1, 1'h0, 2'h0, 32'h2, 1'h0);
         chk(res, 2'h0);
         chk(n_stb, 0);
      end
      slave_enable_in <= 1'h1;
      vme_iack_b_in <= 1'h1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      t_rw();
      t_d16();
      t_err_retry();
      t_decode();
      report_and_stop();
   end
   // The scenarios need about 420 cycles
   initial
   begin
      #100000;
      mismatches++;
      report_and_stop();
   end
endmodule
